// ===== verification/pdcc_enc_model.sv
`timescale 1ns/1ns
`default_nettype none
// quadrature encoder as seen from a servo driver
module pdcc_enc_model (
  input wire logic clk,
  input wire logic step,
  input wire logic dir,
  output logic a,
  output logic b
);
  logic [1:0] ph = 2'h0; // gray phase
  // one quarter cycle per step request
  always @(posedge clk) begin
    if (step) begin
      ph <= dir ? ph + 2'h1 : ph - 2'h1;
    end
  end
  // phases 0..3 give 00, 10, 11, 01 on a, b
  assign a = ph[1] ^ ph[0];
  assign b = ph[1];
endmodule
`default_nettype wire

// ===== verification/pdcc_sva.sv
`timescale 1ns/1ns
`default_nettype none
// port-level checks of the compare block
module pdcc_sva (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic s_axi_awvalid,
  input wire logic s_axi_awready,
  input wire logic s_axi_wvalid,
  input wire logic s_axi_wready,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic s_axi_rvalid,
  input wire logic position_compare_irq_n,
  input wire logic deviation_compare_irq_n,
  input wire logic abrupt_stop_req,
  input wire logic ramped_stop_req
);
  default clocking @(posedge aclk); endclocking
  default disable iff (!aresetn);
  // address and data taken on one edge
  sequence wr_take;
    s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
  endsequence
  // read address taken
  sequence rd_take;
    s_axi_arvalid && s_axi_arready;
  endsequence
  chk_wr_answer: assert property (wr_take |-> ##2 s_axi_bvalid) else $error("write not answered");
  chk_rd_answer: assert property (rd_take |=> s_axi_rvalid) else $error("read not answered");
  chk_ar_block: assert property (s_axi_rvalid |-> !s_axi_arready) else $error("read overlap");
  chk_stop_excl: assert property (!(abrupt_stop_req && ramped_stop_req)) else $error("both stops");
  chk_abrupt_pulse: assert property (abrupt_stop_req |=> !abrupt_stop_req) else $error("abrupt held");
  chk_ramped_pulse: assert property (ramped_stop_req |=> !ramped_stop_req) else $error("ramped held");
  chk_irq_reset: assert property ($rose(aresetn) |-> position_compare_irq_n && deviation_compare_irq_n)
    else $error("irq after reset");
  chk_bus_reset: assert property ($rose(aresetn) |-> !s_axi_bvalid && !s_axi_rvalid && !abrupt_stop_req)
    else $error("bus after reset");
endmodule
bind pdcc_top pdcc_sva pdcc_sva_inst (.aclk, .aresetn, .s_axi_awvalid, .s_axi_awready, .s_axi_wvalid,
  .s_axi_wready, .s_axi_bvalid, .s_axi_arvalid, .s_axi_arready, .s_axi_rvalid, .position_compare_irq_n,
  .deviation_compare_irq_n, .abrupt_stop_req, .ramped_stop_req);
`default_nettype wire

// ===== verification/testbench.sv
`timescale 1ns/1ns
`default_nettype none
module testbench;
  import pdcc_pkg::*;
  typedef struct {logic wr; logic [7:0] ad; logic [31:0] d; logic [1:0] rs;} pdcc_row_t;
  logic aclk = 1'h0;
  logic aresetn = 1'h0;
  logic [7:0] s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
  logic [31:0] s_axi_wdata = 32'h0000_0000, s_axi_rdata, rd;
  logic [3:0] s_axi_wstrb = 4'hF;
  logic s_axi_awvalid = 1'h0, s_axi_wvalid = 1'h0, s_axi_bready = 1'h0, s_axi_arvalid = 1'h0, s_axi_rready = 1'h0;
  logic gen_pulse = 1'h0, gen_dir = 1'h1, pstep = 1'h0, dstep = 1'h0;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [1:0] s_axi_bresp, s_axi_rresp, rsp;
  logic pos_a_pin, pos_b_pin, dev_a_pin, dev_b_pin, position_compare_irq_n, deviation_compare_irq_n;
  logic abrupt_stop_req, ramped_stop_req;
  int mismatches = 0, n_tests = 0, n_abrupt = 0, n_ramped = 0, n_hi = 0;
  // register accesses: reads hold the expected low 24 bits
  pdcc_row_t rows [14] = '{
    '{1'h0, OFS_CTRL, 32'h0000_0000, RESP_OKAY},
    '{1'h0, OFS_POS, 32'h0000_0000, RESP_OKAY},
    '{1'h0, OFS_DEV, 32'h0000_0000, RESP_OKAY},
    '{1'h0, OFS_STAT3, 32'h0000_0040, RESP_OKAY},
    '{1'h0, 8'h40, 32'h0000_0000, RESP_SLVERR},
    '{1'h1, 8'h3C, 32'h0000_0001, RESP_SLVERR},
    '{1'h1, OFS_MASK, 32'h0000_007F, RESP_OKAY},
    '{1'h0, OFS_MASK, 32'h0000_007F, RESP_OKAY},
    '{1'h1, OFS_MASK, 32'h0000_0000, RESP_OKAY},
    '{1'h1, OFS_DATA, 32'h00FF_FFF6, RESP_OKAY},
    '{1'h1, OFS_CMD, 32'h0000_0000, RESP_OKAY},
    '{1'h0, OFS_POS, 32'h00FF_FFF6, RESP_OKAY},
    '{1'h0, OFS_CMD, 32'h0000_0000, RESP_OKAY},
    '{1'h0, OFS_DEV, 32'h0000_0000, RESP_OKAY}};
  pdcc_top pdcc_top_inst (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
    .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr,
    .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .gen_pulse,
    .gen_dir, .pos_a_pin, .pos_b_pin, .dev_a_pin, .dev_b_pin, .position_compare_irq_n,
    .deviation_compare_irq_n, .abrupt_stop_req, .ramped_stop_req);
  pdcc_enc_model pdcc_enc_model_inst (.clk(aclk), .step(pstep), .dir(1'h1), .a(pos_a_pin), .b(pos_b_pin));
  pdcc_enc_model pdcc_enc_model_inst_b (.clk(aclk), .step(dstep), .dir(1'h1), .a(dev_a_pin), .b(dev_b_pin));
  // clock
  always #25 aclk = ~aclk;
  // count stop pulses and idle interrupt cycles
  always @(posedge aclk) begin
    if (abrupt_stop_req === 1'h1) n_abrupt++;
    if (ramped_stop_req === 1'h1) n_ramped++;
    if (position_compare_irq_n === 1'h1) n_hi++;
  end
  // compare and report
  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    n_tests++;
    if (seen !== exp) begin
      mismatches++;
      $display("[ERR] %s exp %h seen %h", nm, exp, seen);
    end
  endtask
  // bus write, address and data offered together
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic aw, w;
    @(posedge aclk);
    aw = 1'h0;
    w = 1'h0;
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'h1;
    s_axi_wvalid <= 1'h1;
    s_axi_bready <= 1'h1;
    do begin
      @(posedge aclk);
      if (!aw && s_axi_awready === 1'h1) begin
        aw = 1'h1;
        s_axi_awvalid <= 1'h0;
      end
      if (!w && s_axi_wready === 1'h1) begin
        w = 1'h1;
        s_axi_wvalid <= 1'h0;
      end
    end while (s_axi_bvalid !== 1'h1);
    s_axi_bready <= 1'h0;
    rsp = s_axi_bresp;
  endtask
  // bus read into rd and rsp
  task automatic rdt(input logic [7:0] a);
    @(posedge aclk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'h1;
    s_axi_rready <= 1'h1;
    do begin
      @(posedge aclk);
      if (s_axi_arready === 1'h1) s_axi_arvalid <= 1'h0;
    end while (s_axi_rvalid !== 1'h1);
    s_axi_rready <= 1'h0;
    rd = s_axi_rdata;
    rsp = s_axi_rresp;
  endtask
  // counter command with its data word
  task automatic cmd(input logic [3:0] c, input logic [31:0] d);
    wr(OFS_DATA, d);
    wr(OFS_CMD, {28'h000_0000, c});
  endtask
  // generated pulses in one direction
  task automatic pulses(input int n, input logic dir);
    repeat (n) begin
      @(posedge aclk);
      gen_pulse <= 1'h1;
      gen_dir <= dir;
      @(posedge aclk);
      gen_pulse <= 1'h0;
    end
  endtask
  // encoder quarter steps, spaced for the pin synchronisers
  task automatic steps(input int n, input logic p);
    repeat (n) begin
      @(posedge aclk);
      if (p) pstep <= 1'h1;
      else dstep <= 1'h1;
      @(posedge aclk);
      pstep <= 1'h0;
      dstep <= 1'h0;
      repeat (4) @(posedge aclk);
    end
  endtask
  task automatic close_out;
    $display("checks %0d mismatches %0d", n_tests, mismatches);
    if (mismatches == 0 && n_tests > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  // hang guard
  initial begin
    repeat (20000) @(posedge aclk);
    mismatches++;
    close_out;
  end
  initial begin
    repeat (3) @(posedge aclk);
    aresetn <= 1'h1;
    foreach (rows[i]) begin
      if (rows[i].wr) begin
        wr(rows[i].ad, rows[i].d);
        chk("bresp", rsp, rows[i].rs);
      end else begin
        rdt(rows[i].ad);
        chk("rdata", rd & 32'h00FF_FFFF, rows[i].d);
        chk("rresp", rsp, rows[i].rs);
      end
    end
    cmd(CMD_POS_PRESET, 0);
    pulses(3, 1'h1);
    pulses(1, 1'h0);
    rdt(OFS_POS);
    chk("pos", rd[23:0], 2);
    cmd(4'h1, 5);
    wr(OFS_INTEN, 1);
    wr(OFS_STOPEN, 1);
    pulses(3, 1'h1);
    repeat (3) @(posedge aclk);
    chk("abrupt", n_abrupt, 1);
    chk("pirq", position_compare_irq_n, 0);
    rdt(OFS_STAT3);
    chk("st", {rd[8], rd[0]}, 3);
    rdt(OFS_STAT3);
    chk("lvl", {rd[8], rd[0]}, 1);
    pulses(1, 1'h1);
    rdt(OFS_STAT3);
    rdt(OFS_STAT3);
    chk("lvlclr", rd[0], 0);
    chk("pirq", position_compare_irq_n, 1);
    wr(OFS_CTRL, 32'h0000_4100);
    cmd(CMD_POS_PRESET, 4);
    pulses(1, 1'h1);
    rdt(OFS_STAT3);
    chk("edge", {rd[9], rd[0]}, 3);
    rdt(OFS_STAT3);
    chk("edgeclr", rd[0], 0);
    wr(OFS_MASK, 1);
    cmd(CMD_POS_PRESET, 4);
    pulses(1, 1'h1);
    rdt(OFS_STAT3);
    chk("masked", rd[0], 0);
    chk("ramped", n_ramped, 2);
    wr(OFS_MASK, 0);
    wr(OFS_CTRL, 32'h0000_0400);
    repeat (3) @(posedge aclk);
    chk("thru", position_compare_irq_n, 0);
    n_hi = 0;
    wr(OFS_CMD, 3);
    repeat (6) @(posedge aclk);
    chk("blank", n_hi, int'(BLANK_CYC));
    cmd(CMD_POS_PRESET, 6);
    cmd(4'h1, 7);
    wr(OFS_DATA, 9);
    wr(OFS_CTRL, 32'h0000_3000);
    pulses(1, 1'h1);
    rdt(OFS_POS);
    chk("aclr", rd[23:0], 0);
    wr(OFS_CTRL, 0);
    pulses(9, 1'h1);
    repeat (3) @(posedge aclk);
    chk("reload", n_abrupt, 3);
    cmd(CMD_POS_PRESET, 32'h007F_FFFF);
    pulses(1, 1'h1);
    rdt(OFS_STAT3);
    chk("wrap", rd[7], 1);
    cmd(CMD_DEV_PRESET, 0);
    steps(8, 1'h0);
    rdt(OFS_DEV);
    chk("dev", rd[23:0], 24'hFF_FFFE);
    cmd(CMD_DEV_CMP1, 2);
    wr(OFS_INTEN, 32'h0000_0020);
    repeat (3) @(posedge aclk);
    chk("dirq", deviation_compare_irq_n, 0);
    wr(OFS_CTRL, 9);
    cmd(CMD_POS_PRESET, 0);
    steps(4, 1'h1);
    pulses(1, 1'h1);
    rdt(OFS_POS);
    chk("ext", rd[23:0], 4);
    wr(OFS_CTRL, 3);
    cmd(CMD_POS_PRESET, 0);
    steps(1, 1'h1);
    rdt(OFS_POS);
    chk("ud", rd[23:0], 1);
    steps(1, 1'h1);
    rdt(OFS_POS);
    chk("ud", rd[23:0], 0);
    @(posedge aclk);
    aresetn <= 1'h0;
    repeat (3) @(posedge aclk);
    aresetn <= 1'h1;
    rdt(OFS_POS);
    chk("rstpos", rd[23:0], 0);
    rdt(OFS_CTRL);
    chk("rstctl", rd, 0);
    close_out;
  end
endmodule
`default_nettype wire

// ===== verilog/pdcc_pkg.sv
// shared constants for the pulse and deviation counter compare block
package pdcc_pkg;
  // counter and bus widths
  localparam int CNT_W = 24; // both counters and all compare registers
  localparam int ADDR_W = 8; // byte address width of the register window
  localparam int DATA_W = 32; // bus data width
  localparam int NCMP_POS = 5; // position comparators
  localparam int NCMP = 7; // five position plus two deviation comparators
  // register byte offsets
  localparam logic [7:0] OFS_CTRL = 8'h00; // setup bits of both counters
  localparam logic [7:0] OFS_INTEN = 8'h04; // interrupt output enables
  localparam logic [7:0] OFS_STOPEN = 8'h08; // comparator stop enables
  localparam logic [7:0] OFS_MASK = 8'h0C; // compare mask stage
  localparam logic [7:0] OFS_DATA = 8'h10; // counter data word
  localparam logic [7:0] OFS_CMD = 8'h14; // counter command code
  localparam logic [7:0] OFS_STAT3 = 8'h18; // third status port
  localparam logic [7:0] OFS_POS = 8'h1C; // position counter readback
  localparam logic [7:0] OFS_DEV = 8'h20; // deviation counter readback
  // control register fields
  localparam int B_POS_EXT = 0; // position counter counts external clock
  localparam int B_POS_UD = 1; // external position clock is up/down pair
  localparam int B_POS_MUL = 2; // two bits, position quadrature multiplier
  localparam int B_DEV_EXTONLY = 4; // deviation counts feedback alone
  localparam int B_DEV_UD = 5; // feedback is up/down pair
  localparam int B_DEV_MUL = 6; // two bits, feedback multiplier
  localparam int B_POS_EDGE = 8; // position group uses edge latch
  localparam int B_DEV_EDGE = 9; // deviation group uses edge latch
  localparam int B_POS_THRU = 10; // position group passes straight through
  localparam int B_DEV_THRU = 11; // deviation group passes straight through
  localparam int B_AUTOCLR = 12; // clear position counter on compare 1 match
  localparam int B_RELOAD = 13; // reload compare 1 on its match
  localparam int B_STOP_RAMP = 14; // stop by deceleration instead of abruptly
  localparam int CTRL_W = 15;
  localparam logic [CTRL_W-1:0] CTRL_RST = 15'h0000; // latch mode, own pulses, x1 quadrature
  // multiplier codes
  localparam logic [1:0] MUL_X1 = 2'h0;
  localparam logic [1:0] MUL_X2 = 2'h1;
  // status word fields
  localparam int B_WRAP = 7; // count_wrap_flag
  localparam int B_ABRUPT = 8; // abrupt_stop_flag
  localparam int B_RAMPED = 9; // ramped_stop_flag
  // counter commands
  localparam logic [3:0] CMD_POS_PRESET = 4'h0;
  localparam logic [3:0] CMD_POS_CMP5 = 4'h5;
  localparam logic [3:0] CMD_DEV_PRESET = 4'h6;
  localparam logic [3:0] CMD_DEV_CMP1 = 4'h7;
  localparam logic [3:0] CMD_DEV_CMP2 = 4'h8;
  // reset values
  localparam logic [23:0] CNT_RST = 24'h00_0000;
  localparam logic [23:0] POS_CMP_RST = 24'h80_0000;
  localparam logic [23:0] DEV_CMP1_RST = 24'h7F_FFFF;
  localparam logic [23:0] DEV_CMP2_RST = 24'h00_0000;
  localparam logic [23:0] WRAP_VAL = 24'h80_0000; // magnitude 8388608
  localparam logic [23:0] ONE = 24'h00_0001;
  // bus responses
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  // timing
  localparam int CLK_MHZ = 20;
  localparam int BLANK_NS = 50; // through-mode interrupt blanking
  localparam int BLANK_CYC_I = (BLANK_NS * CLK_MHZ + 999) / 1000;
  localparam logic [3:0] BLANK_CYC = 4'(BLANK_CYC_I < 1 ? 1 : BLANK_CYC_I);
endpackage

// ===== verilog/pdcc_top.sv
// Operation
// - position counter counts own pulses or external clock
// - position readable; reaching 8388608 sets wrap flag
// - position clears on reset, preset command loads
// - external quadrature or up/down, own pulses after reset
// - five compare registers checked for equality continuously
// - per-group through or latch, level or edge latch
// - status read clears level latch only when idle
// - both groups reset to latched output
// - position irq ORs five comparators, individually enabled
// - per-comparator mask, writable at any time
// - status shows compare signal after output type stage regardless of enable
// - through mode: counter command blanks irq 50 ns
// - compare match stops output abruptly or ramped
// - stop acts on raw comparator result
// - compare data written via separate counter port
// - auto clear zeroes position on compare 1 match
// - reload refills compare 1 from data on match
// - deviation counts difference or external clock alone
// - deviation readable, zero at reset, preset loads
// - deviation reset: x1 quadrature, differential mode
// - abs deviation >= reg1 excessive, <= reg2 complete
// - deviation irq ORs two comparators, individually enabled
// - command low nibble selects preset or compare register
// - compare data taken as 24-bit two's complement
`timescale 1ns/1ns
`default_nettype none
module pdcc_top (
  input wire logic aclk,
  input wire logic aresetn,
  // axi4-lite write address
  input wire logic [pdcc_pkg::ADDR_W-1:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  // axi4-lite write data
  input wire logic [pdcc_pkg::DATA_W-1:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  // axi4-lite write response
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  // axi4-lite read address
  input wire logic [pdcc_pkg::ADDR_W-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  // axi4-lite read data
  output logic [pdcc_pkg::DATA_W-1:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // generated pulse stream, same clock
  input wire logic gen_pulse,
  input wire logic gen_dir,
  // external position clock pins, a and b phase
  input wire logic pos_a_pin,
  input wire logic pos_b_pin,
  // servo feedback pins, a and b phase
  input wire logic dev_a_pin,
  input wire logic dev_b_pin,
  // interrupt and stop outputs
  output logic position_compare_irq_n,
  output logic deviation_compare_irq_n,
  output logic abrupt_stop_req,
  output logic ramped_stop_req
);
  import pdcc_pkg::*;

  // merge a bus write into a register through byte strobes
  function automatic logic [31:0] wmerge(input logic [31:0] old, input logic [31:0] d, input logic [3:0] s);
    logic [31:0] r;
    r = old;
    for (int i = 0; i < 4; i++) begin
      if (s[i]) begin
        r[i*8 +: 8] = d[i*8 +: 8];
      end
    end
    return r;
  endfunction

  // turn a sampled pin pair into an up/down step, bit1 up and bit0 down
  function automatic logic [1:0] step(input logic [1:0] p, input logic [1:0] c, input logic [1:0] mul,
                                      input logic ud);
    logic ea;
    logic eb;
    logic a_up;
    logic [1:0] r;
    ea = p[0] ^ c[0];
    eb = p[1] ^ c[1];
    a_up = c[0] ^ c[1];
    r = 2'b00;
    if (ud) begin
      r = {c[0] & ~p[0], c[1] & ~p[1]}; // a rising up, b rising down
    end else if (mul == MUL_X1) begin
      r = {ea & c[0] & ~c[1], ea & ~c[0] & ~c[1]}; // a edges with b low only
    end else if (mul == MUL_X2) begin
      r = {ea & a_up, ea & ~a_up}; // both a edges
    end else if (ea != eb) begin
      r = ea ? {a_up, ~a_up} : {~a_up, a_up}; // all four edges
    end
    return r;
  endfunction

  // configuration and working registers
  logic [CTRL_W-1:0] ctrl_r; // setup bits, both setup commands
  logic [NCMP-1:0] inten_r; // interrupt output enables
  logic [NCMP-1:0] stopen_r; // comparator stop enables
  logic [NCMP-1:0] mask_r; // compare mask stage
  logic [31:0] data_r; // counter data port
  logic [CNT_W-1:0] pos_r; // position counter
  logic [CNT_W-1:0] pos_nxt;
  logic [CNT_W-1:0] dev_r; // deviation counter
  logic [CNT_W-1:0] dev_nxt;
  logic [CNT_W-1:0] pcmp_r [NCMP_POS]; // position compare registers
  logic [CNT_W-1:0] dcmp1_r; // excessive deviation threshold
  logic [CNT_W-1:0] dcmp2_r; // positioning complete threshold
  logic [CNT_W-1:0] dev_abs;
  logic [NCMP-1:0] raw; // comparator results
  logic [NCMP-1:0] masked; // after mask stage
  logic [NCMP-1:0] masked_prev_r; // for edge latch
  logic [NCMP-1:0] latch_r; // latch stage
  logic [NCMP-1:0] cmp_out; // after output type stage
  logic [NCMP-1:0] raw_prev_r; // for stop edge detect
  logic wrap_r;
  logic abrupt_r;
  logic ramped_r;
  logic [3:0] blank_r; // irq blanking countdown
  // pin synchronisers, bit1 is b phase
  logic [1:0] pos_s1_r;
  logic [1:0] pos_s2_r;
  logic [1:0] pos_prev_r;
  logic [1:0] dev_s1_r;
  logic [1:0] dev_s2_r;
  logic [1:0] dev_prev_r;
  logic [1:0] pos_step;
  logic [1:0] fb_step;
  // bus state
  logic [ADDR_W-1:0] aw_addr_r;
  logic aw_have_r;
  logic [31:0] w_data_r;
  logic [3:0] w_strb_r;
  logic w_have_r;
  logic wr_do;
  logic rd_do;
  logic [31:0] rd_word;
  logic rd_ok;
  logic wr_ok;
  logic cmd_do; // counter command executes this cycle
  logic [3:0] cmd_code;
  logic stat_rd; // third status port read accepted

  // two-flop synchronisers on all external pins, then edge history
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      pos_s1_r <= 2'b00;
      pos_s2_r <= 2'b00;
      pos_prev_r <= 2'b00;
      dev_s1_r <= 2'b00;
      dev_s2_r <= 2'b00;
      dev_prev_r <= 2'b00;
    end else begin
      pos_s1_r <= {pos_b_pin, pos_a_pin};
      pos_s2_r <= pos_s1_r;
      pos_prev_r <= pos_s2_r;
      dev_s1_r <= {dev_b_pin, dev_a_pin};
      dev_s2_r <= dev_s1_r;
      dev_prev_r <= dev_s2_r;
    end
  end

  assign pos_step = step(pos_prev_r, pos_s2_r, ctrl_r[B_POS_MUL +: 2], ctrl_r[B_POS_UD]);
  assign fb_step = step(dev_prev_r, dev_s2_r, ctrl_r[B_DEV_MUL +: 2], ctrl_r[B_DEV_UD]);

  // write channel: address and data taken in either order
  assign s_axi_awready = !aw_have_r && !s_axi_bvalid;
  assign s_axi_wready = !w_have_r && !s_axi_bvalid;
  assign wr_do = aw_have_r && w_have_r;
  assign wr_ok = (aw_addr_r <= OFS_CMD) && (aw_addr_r[1:0] == 2'b00);
  assign cmd_do = wr_do && aw_addr_r == OFS_CMD && w_strb_r[0];
  assign cmd_code = w_data_r[3:0];

  // write address and data holding
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_have_r <= 1'b0;
      w_have_r <= 1'b0;
      aw_addr_r <= '0;
      w_data_r <= 32'h0000_0000;
      w_strb_r <= 4'h0;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_have_r <= 1'b1;
        aw_addr_r <= s_axi_awaddr;
      end else if (wr_do) begin
        aw_have_r <= 1'b0;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_have_r <= 1'b1;
        w_data_r <= s_axi_wdata;
        w_strb_r <= s_axi_wstrb;
      end else if (wr_do) begin
        w_have_r <= 1'b0;
      end
    end
  end

  // write response, one cycle after both halves are held
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= RESP_OKAY;
    end else if (wr_do) begin
      s_axi_bvalid <= 1'b1;
      s_axi_bresp <= wr_ok ? RESP_OKAY : RESP_SLVERR;
    end else if (s_axi_bready) begin
      s_axi_bvalid <= 1'b0;
    end
  end

  // setup, enable, mask and data registers
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ctrl_r <= CTRL_RST;
      inten_r <= '0;
      stopen_r <= '0;
      mask_r <= '0;
      data_r <= 32'h0000_0000;
    end else if (wr_do) begin
      case (aw_addr_r)
        OFS_CTRL: ctrl_r <= CTRL_W'(wmerge(32'(ctrl_r), w_data_r, w_strb_r));
        OFS_INTEN: inten_r <= NCMP'(wmerge(32'(inten_r), w_data_r, w_strb_r));
        OFS_STOPEN: stopen_r <= NCMP'(wmerge(32'(stopen_r), w_data_r, w_strb_r));
        OFS_MASK: mask_r <= NCMP'(wmerge(32'(mask_r), w_data_r, w_strb_r));
        OFS_DATA: data_r <= wmerge(data_r, w_data_r, w_strb_r);
        default: begin
        end
      endcase
    end
  end

  // read channel: registered answer one cycle after the address
  assign s_axi_arready = !s_axi_rvalid;
  assign rd_do = s_axi_arvalid && s_axi_arready;
  assign stat_rd = rd_do && s_axi_araddr == OFS_STAT3;

  // read decode
  always_comb begin
    rd_word = 32'h0000_0000;
    rd_ok = 1'b1;
    case (s_axi_araddr)
      OFS_CTRL: rd_word = 32'(ctrl_r);
      OFS_INTEN: rd_word = 32'(inten_r);
      OFS_STOPEN: rd_word = 32'(stopen_r);
      OFS_MASK: rd_word = 32'(mask_r);
      OFS_DATA: rd_word = data_r;
      OFS_CMD: rd_word = 32'h0000_0000;
      OFS_STAT3: rd_word = 32'({ramped_r, abrupt_r, wrap_r, cmp_out});
      OFS_POS: rd_word = 32'(pos_r);
      OFS_DEV: rd_word = 32'(dev_r);
      default: rd_ok = 1'b0;
    endcase
  end

  // read data register
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h0000_0000;
      s_axi_rresp <= RESP_OKAY;
    end else if (rd_do) begin
      s_axi_rvalid <= 1'b1;
      s_axi_rdata <= rd_word;
      s_axi_rresp <= rd_ok ? RESP_OKAY : RESP_SLVERR;
    end else if (s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
    end
  end

  // position counter next value
  always_comb begin
    logic up;
    logic dn;
    up = ctrl_r[B_POS_EXT] ? pos_step[1] : gen_pulse & gen_dir;
    dn = ctrl_r[B_POS_EXT] ? pos_step[0] : gen_pulse & ~gen_dir;
    pos_nxt = pos_r;
    if (cmd_do && cmd_code == CMD_POS_PRESET) begin
      pos_nxt = data_r[CNT_W-1:0];
    end else if (ctrl_r[B_AUTOCLR] && raw[0]) begin
      pos_nxt = CNT_RST;
    end else if (up && !dn) begin
      pos_nxt = pos_r + ONE;
    end else if (dn && !up) begin
      pos_nxt = pos_r - ONE;
    end
  end

  // deviation counter next value
  always_comb begin
    logic up;
    logic dn;
    // feedback alone, or generated pulses against feedback
    up = ctrl_r[B_DEV_EXTONLY] ? fb_step[1] : (gen_pulse & gen_dir) | fb_step[0];
    dn = ctrl_r[B_DEV_EXTONLY] ? fb_step[0] : (gen_pulse & ~gen_dir) | fb_step[1];
    dev_nxt = dev_r;
    if (cmd_do && cmd_code == CMD_DEV_PRESET) begin
      dev_nxt = data_r[CNT_W-1:0];
    end else if (up && !dn) begin
      dev_nxt = dev_r + ONE;
    end else if (dn && !up) begin
      dev_nxt = dev_r - ONE;
    end
  end

  // counters and wrap flag
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      pos_r <= CNT_RST;
      dev_r <= CNT_RST;
      wrap_r <= 1'b0;
    end else begin
      pos_r <= pos_nxt;
      dev_r <= dev_nxt;
      if (pos_nxt == WRAP_VAL && pos_r != WRAP_VAL) begin
        wrap_r <= 1'b1;
      end else if (stat_rd) begin
        wrap_r <= 1'b0;
      end
    end
  end

  // compare registers written by counter commands
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      for (int i = 0; i < NCMP_POS; i++) begin
        pcmp_r[i] <= POS_CMP_RST;
      end
      dcmp1_r <= DEV_CMP1_RST;
      dcmp2_r <= DEV_CMP2_RST;
    end else begin
      for (int i = 0; i < NCMP_POS; i++) begin
        if (cmd_do && cmd_code == 4'(i + 1)) begin
          pcmp_r[i] <= data_r[CNT_W-1:0];
        end else if (i == 0 && ctrl_r[B_RELOAD] && raw[0]) begin
          pcmp_r[i] <= data_r[CNT_W-1:0];
        end
      end
      if (cmd_do && cmd_code == CMD_DEV_CMP1) begin
        dcmp1_r <= data_r[CNT_W-1:0];
      end
      if (cmd_do && cmd_code == CMD_DEV_CMP2) begin
        dcmp2_r <= data_r[CNT_W-1:0];
      end
    end
  end

  // comparators and mask stage
  assign dev_abs = dev_r[CNT_W-1] ? CNT_W'(0 - dev_r) : dev_r;
  generate
    for (genvar g = 0; g < NCMP_POS; g++) begin : g_pcmp
      assign raw[g] = pos_r == pcmp_r[g];
    end
  endgenerate
  assign raw[NCMP_POS] = dev_abs >= dcmp1_r;
  assign raw[NCMP_POS+1] = dev_abs <= dcmp2_r;
  assign masked = raw & ~mask_r;

  // latch stage: level or edge trigger per group, set wins over clear
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      latch_r <= '0;
      masked_prev_r <= '0;
    end else begin
      masked_prev_r <= masked;
      for (int i = 0; i < NCMP; i++) begin
        if (ctrl_r[i < NCMP_POS ? B_POS_EDGE : B_DEV_EDGE]) begin
          if (masked[i] && !masked_prev_r[i]) begin
            latch_r[i] <= 1'b1;
          end else if (stat_rd) begin
            latch_r[i] <= 1'b0;
          end
        end else begin
          if (masked[i]) begin
            latch_r[i] <= 1'b1;
          end else if (stat_rd) begin
            latch_r[i] <= 1'b0;
          end
        end
      end
    end
  end

  // output type stage per group
  assign cmp_out[NCMP_POS-1:0] = ctrl_r[B_POS_THRU] ? masked[NCMP_POS-1:0] : latch_r[NCMP_POS-1:0];
  assign cmp_out[NCMP-1:NCMP_POS] = ctrl_r[B_DEV_THRU] ? masked[NCMP-1:NCMP_POS] : latch_r[NCMP-1:NCMP_POS];

  // blanking after a counter command
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      blank_r <= 4'h0;
    end else if (cmd_do && cmd_code <= CMD_DEV_CMP2) begin
      blank_r <= BLANK_CYC - 4'h1; // the command cycle blanks first
    end else if (blank_r != 4'h0) begin
      blank_r <= blank_r - 4'h1;
    end
  end

  // interrupt lines from registers, enable stage and blanking
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      position_compare_irq_n <= 1'b1;
      deviation_compare_irq_n <= 1'b1;
    end else begin
      position_compare_irq_n <= !(|(cmp_out[NCMP_POS-1:0] & inten_r[NCMP_POS-1:0]) &&
        !(ctrl_r[B_POS_THRU] && (blank_r != 4'h0 || cmd_do)));
      deviation_compare_irq_n <= !(|(cmp_out[NCMP-1:NCMP_POS] & inten_r[NCMP-1:NCMP_POS]) &&
        !(ctrl_r[B_DEV_THRU] && (blank_r != 4'h0 || cmd_do)));
    end
  end

  // stop requests on a fresh raw match, ahead of mask and latch
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      raw_prev_r <= '0;
      abrupt_stop_req <= 1'b0;
      ramped_stop_req <= 1'b0;
      abrupt_r <= 1'b0;
      ramped_r <= 1'b0;
    end else begin
      raw_prev_r <= raw;
      abrupt_stop_req <= 1'b0;
      ramped_stop_req <= 1'b0;
      if (|(raw & ~raw_prev_r & stopen_r)) begin
        if (ctrl_r[B_STOP_RAMP]) begin
          ramped_stop_req <= 1'b1;
          ramped_r <= 1'b1;
        end else begin
          abrupt_stop_req <= 1'b1;
          abrupt_r <= 1'b1;
        end
      end else if (stat_rd) begin
        abrupt_r <= 1'b0;
        ramped_r <= 1'b0;
      end
    end
  end
endmodule
`default_nettype wire
